/* src/sesb_top.sv */
// Contract
// - Loop lock attained sets event bit 0.
// - Loop lock lost sets event bit 1.
// - Loop entering holdover sets event bit 2.
// - Loop switching reference sets event bit 3.
// - Event bits stay set until the event register is read; the read clears them.
// - Monitor failure flag reads one while failure indicated; the flag is sticky.
// - Even reference in bits 3:0, odd in 7:4; cycle, coarse, guard, precise.
// - References 0/1 at 0x05, 2/3 at 0x06, 4/5 at 0x07.
// - Reference 6 low nibble, reference 7 high nibble, at 0x08.
// - Eight-bit reference failure mask; zero suppresses that reference's interrupt.
// - Mask bit i controls reference i, bit 0 reference 0, bit 7 reference 7.
// - Summary bit i is one when reference i has a failure.
// - Event enable bits 3:0 at one let each event raise the interrupt.
// - Per-reference monitor enable, one bit per monitor type; zero masks it.
`timescale 1ns/1ps
`include "sesb_defines.svh"

module sesb_top #(
  parameter int AW = 8
) (
  input  wire logic                   pclk,      // System clock, 200 MHz
  input  wire logic                   presetn,   // Async reset, active low
  input  wire logic                   psel,      // APB select
  input  wire logic                   penable,   // APB enable
  input  wire logic                   pwrite,    // APB direction
  input  wire logic [AW-1:0]          paddr,     // APB byte address
  input  wire logic [31:0]            pwdata,    // APB write data
  input  wire logic [3:0]             pstrb,     // APB byte strobes
  output logic      [31:0]            prdata,    // APB read data
  output logic                        pready,    // APB ready
  output logic                        pslverr,   // APB error, unmapped address
  input  wire sesb_pkg::sesb_loop_evt_t loop_evt,  // Loop event pulses
  input  wire sesb_pkg::sesb_mon_t [7:0] mon_fail, // Monitor failure levels
  output logic                        irq        // Interrupt request, active high
);
  import sesb_pkg::*;

  localparam int NREF = 8;

  logic [`SESB_EVT_W-1:0]       evt_q,      evt_d;
  logic [NREF*`SESB_MON_W-1:0]  mon_q,      mon_d;
  logic [NREF-1:0]              ref_en_q,   ref_en_d;
  logic [`SESB_EVT_W-1:0]       evt_en_q,   evt_en_d;
  logic [NREF*`SESB_MON_W-1:0]  mon_en_q,   mon_en_d;
  logic [31:0]                  prdata_q,   prdata_d;
  logic                         pready_q,   pready_d;
  logic                         pslverr_q,  pslverr_d;
  logic                         irq_q,      irq_d;

  // Address decode
  wire [5:0] idx     = paddr[7:2];
  wire       aligned = (paddr[1:0] == 2'b00);
  wire sel_sum  = aligned && (idx == `SESB_IDX_REF_FAIL_SUM);
  wire sel_evt  = aligned && (idx == `SESB_IDX_LOOP_EVT);
  wire sel_ren  = aligned && (idx == `SESB_IDX_REF_FAIL_EN);
  wire sel_een  = aligned && (idx == `SESB_IDX_LOOP_EVT_EN);
  wire [3:0] sel_mon = {aligned && (idx == `SESB_IDX_MON67),
                        aligned && (idx == `SESB_IDX_MON45),
                        aligned && (idx == `SESB_IDX_MON23),
                        aligned && (idx == `SESB_IDX_MON01)};
  wire [3:0] sel_men = {aligned && (idx == `SESB_IDX_MON_EN67),
                        aligned && (idx == `SESB_IDX_MON_EN45),
                        aligned && (idx == `SESB_IDX_MON_EN23),
                        aligned && (idx == `SESB_IDX_MON_EN01)};
  wire mapped = sel_sum | sel_evt | sel_ren | sel_een | (|sel_mon) | (|sel_men);

  // Bus phases; the answer is always ready in the first access cycle
  wire setup = psel & ~penable;
  wire done  = psel & penable & pready_q;
  wire wr    = done & pwrite & pstrb[0];
  wire rd    = done & ~pwrite;

  // Per-reference summary and enabled-failure terms
  logic [NREF-1:0] ref_sum;
  logic [NREF-1:0] ref_hit;
  logic [NREF*`SESB_MON_W-1:0] mon_clr;
  logic [NREF*`SESB_MON_W-1:0] mon_in;
  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_ref
      assign mon_in[g*`SESB_MON_W +: `SESB_MON_W] = mon_fail[g];
      assign ref_sum[g] = |mon_q[g*`SESB_MON_W +: `SESB_MON_W];
      assign ref_hit[g] = |(mon_q[g*`SESB_MON_W +: `SESB_MON_W]
                          & mon_en_q[g*`SESB_MON_W +: `SESB_MON_W]);
    end
    for (g = 0; g < NREF/2; g++) begin : g_pair
      // Only the bits that were shown to software get cleared
      assign mon_clr[g*`SESB_REG_W +: `SESB_REG_W] =
        (rd && sel_mon[g]) ? prdata_q[`SESB_REG_W-1:0] : 8'h00;
    end
  endgenerate

  // Read mux; reserved bits read as zero
  wire [7:0] rd_mux =
    sel_sum    ? ref_sum :
    sel_evt    ? {4'h0, evt_q} :
    sel_mon[0] ? mon_q[7:0] :
    sel_mon[1] ? mon_q[15:8] :
    sel_mon[2] ? mon_q[23:16] :
    sel_mon[3] ? mon_q[31:24] :
    sel_ren    ? ref_en_q :
    sel_een    ? {4'h0, evt_en_q} :
    sel_men[0] ? mon_en_q[7:0] :
    sel_men[1] ? mon_en_q[15:8] :
    sel_men[2] ? mon_en_q[23:16] :
    sel_men[3] ? mon_en_q[31:24] : 8'h00;

  // Clear only what the read returned, so a new event in the read is kept
  wire [3:0] evt_clr = (rd && sel_evt) ? prdata_q[3:0] : 4'h0;

  assign evt_d = (evt_q & ~evt_clr) | loop_evt;
  assign mon_d = (mon_q & ~mon_clr) | mon_in;

  assign ref_en_d = (wr && sel_ren) ? pwdata[7:0] : ref_en_q;
  assign evt_en_d = (wr && sel_een) ? pwdata[3:0] : evt_en_q;
  generate
    for (g = 0; g < NREF/2; g++) begin : g_men
      assign mon_en_d[g*8 +: 8] = (wr && sel_men[g]) ? pwdata[7:0] : mon_en_q[g*8 +: 8];
    end
  endgenerate

  assign prdata_d  = (setup && !pwrite) ? {24'h0, rd_mux} : prdata_q;
  assign pready_d  = setup;
  assign pslverr_d = setup && !mapped;

  // Bit i of the reference mask gates reference i
  assign irq_d = (|(evt_q & evt_en_q)) | (|(ref_hit & ref_en_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q    <= 4'h0;
      mon_q    <= 32'h0;
      ref_en_q <= `SESB_RST_REF_FAIL_EN;
      evt_en_q <= `SESB_RST_LOOP_EVT_EN;
      mon_en_q <= `SESB_RST_MON_EN;
    end else begin
      evt_q    <= evt_d;
      mon_q    <= mon_d;
      ref_en_q <= ref_en_d;
      evt_en_q <= evt_en_d;
      mon_en_q <= mon_en_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_evt_lock_set: assert property (
    loop_evt.locked |=> evt_q[0] ##1 (evt_q[0] || $past(rd && sel_evt)))
    else $error("lock event not recorded in bit 0");

  chk_evt_lost_set: assert property (
    loop_evt.lost_lock |=> evt_q[1])
    else $error("lock loss event not recorded in bit 1");

  chk_evt_hold_set: assert property (
    loop_evt.holdover |=> evt_q[2])
    else $error("holdover event not recorded in bit 2");

  chk_evt_switch_set: assert property (
    loop_evt.ref_changed |=> evt_q[3])
    else $error("reference switch event not recorded in bit 3");

  chk_evt_read_clear: assert property (
    (rd && sel_evt && prdata_q[0] && !loop_evt.locked) |=> !evt_q[0])
    else $error("event bit not cleared by read");

  chk_evt_stays_set: assert property (
    (evt_q != 4'h0 && !(rd && sel_evt)) |=> ((evt_q & $past(evt_q)) == $past(evt_q)))
    else $error("event bit dropped without a read");

  chk_set_wins_read: assert property (
    (rd && sel_evt && loop_evt.lost_lock) |=> evt_q[1])
    else $error("event lost during clearing read");

  chk_mon_capture: assert property (
    (mon_in != 32'h0) |=> ((mon_q & $past(mon_in)) == $past(mon_in)))
    else $error("monitor failure not captured");

  chk_mon_sticky: assert property (
    1'b1 |=> (($past(mon_q) & ~$past(mon_clr) & ~mon_q) == 32'h0))
    else $error("monitor flag dropped without a read");

  chk_mon_layout: assert property (
    mon_fail[1].cycle_mon |=> mon_q[4])
    else $error("odd reference cycle monitor not in bit 4");

  chk_mon_pair_read: assert property (
    (setup && !pwrite && sel_mon[1]) |=> (prdata_q[7:0] == $past(mon_q[15:8])))
    else $error("references 2 and 3 not read at their offset");

  chk_mon_last_read: assert property (
    (setup && !pwrite && sel_mon[3]) |=> (prdata_q[7:0] == $past(mon_q[31:24])))
    else $error("references 6 and 7 not read at their offset");

  chk_sum_read: assert property (
    (setup && !pwrite && sel_sum) |=> (prdata_q[7:0] == $past(ref_sum)))
    else $error("failure summary mismatch");

  chk_irq_equation: assert property (
    1'b1 |=> (irq_q == ((|($past(evt_q) & $past(evt_en_q)))
                     || (|($past(ref_hit) & $past(ref_en_q))))))
    else $error("interrupt does not follow enabled flags");

  chk_irq_masked: assert property (
    (ref_en_q == 8'h00 && evt_en_q == 4'h0) |=> !irq_q)
    else $error("interrupt raised with all masks zero");

  chk_evt_en_irq: assert property (
    (evt_q[2] && evt_en_q[2]) |=> irq_q)
    else $error("enabled holdover event gave no interrupt");

  chk_mon_en_irq: assert property (
    (mon_q[0] && !mon_en_q[0] && mon_q[31:1] == 31'h0 && evt_en_q == 4'h0) |=> !irq_q)
    else $error("masked monitor failure raised interrupt");

  chk_apb_answer: assert property (
    setup |=> pready_q ##1 !pready_q || setup)
    else $error("bus answer not in first access cycle");

  // Each event bit clears on a read that showed it, unless a new event lands then
  chk_evt_lost_clr: assert property (
    (rd && sel_evt && prdata_q[1] && !loop_evt.lost_lock) |=> !evt_q[1])
    else $error("lock loss bit not cleared by read");

  chk_evt_hold_clr: assert property (
    (rd && sel_evt && prdata_q[2] && !loop_evt.holdover) |=> !evt_q[2])
    else $error("holdover bit not cleared by read");

  chk_evt_switch_clr: assert property (
    (rd && sel_evt && prdata_q[3] && !loop_evt.ref_changed) |=> !evt_q[3])
    else $error("reference switch bit not cleared by read");

  chk_evt_hold_keep: assert property (
    (rd && sel_evt && loop_evt.holdover) |=> evt_q[2])
    else $error("holdover event lost during clearing read");

  chk_evt_unread_kept: assert property (
    (rd && sel_evt && !prdata_q[0] && evt_q[0]) |=> evt_q[0])
    else $error("event bit cleared although not yet shown");

  chk_evt_no_spur: assert property (
    (!evt_q[0] && !loop_evt.locked) |=> !evt_q[0])
    else $error("lock bit set without an event");

  chk_evt_rsvd_zero: assert property (
    (setup && !pwrite && sel_evt) |=> (prdata_q[7:4] == 4'h0))
    else $error("reserved event bits not zero");

  // Register placement of the monitor flags
  chk_mon_pair0_read: assert property (
    (setup && !pwrite && sel_mon[0]) |=> (prdata_q[7:0] == $past(mon_q[7:0])))
    else $error("references 0 and 1 not read at their offset");

  chk_mon_pair2_read: assert property (
    (setup && !pwrite && sel_mon[2]) |=> (prdata_q[7:0] == $past(mon_q[23:16])))
    else $error("references 4 and 5 not read at their offset");

  chk_mon_ref7_pos: assert property (
    mon_fail[7].precise_freq |=> mon_q[31])
    else $error("reference 7 precise flag not in top bit");

  chk_mon_ref6_pos: assert property (
    mon_fail[6].cycle_mon |=> mon_q[24])
    else $error("reference 6 cycle flag not in low nibble");

  chk_mon_guard_pos: assert property (
    mon_fail[2].guard_timer |=> mon_q[10])
    else $error("guard timer flag misplaced");

  chk_mon_coarse_pos: assert property (
    mon_fail[0].coarse_freq |=> mon_q[1])
    else $error("coarse frequency flag misplaced");

  chk_mon_read_clear: assert property (
    (rd && sel_mon[0] && prdata_q[0] && !mon_fail[0].cycle_mon) |=> !mon_q[0])
    else $error("monitor flag not cleared by read");

  chk_mon_no_spur: assert property (
    (!mon_q[5] && !mon_fail[1].coarse_freq) |=> !mon_q[5])
    else $error("monitor flag set without a failure");

  // Mask registers take only their own writes
  chk_ref_en_write: assert property (
    (wr && sel_ren) |=> (ref_en_q == $past(pwdata[7:0])))
    else $error("reference mask write lost");

  chk_ref_en_hold: assert property (
    !(wr && sel_ren) |=> $stable(ref_en_q))
    else $error("reference mask changed without a write");

  chk_evt_en_write: assert property (
    (wr && sel_een) |=> (evt_en_q == $past(pwdata[3:0])))
    else $error("event enable write lost");

  chk_mon_en_write: assert property (
    (wr && sel_men[0]) |=> (mon_en_q[7:0] == $past(pwdata[7:0])))
    else $error("monitor enable write lost");

  chk_ref7_irq: assert property (
    (ref_hit[7] && ref_en_q[7]) |=> irq_q)
    else $error("enabled reference 7 failure gave no interrupt");

  chk_ref0_irq: assert property (
    (ref_hit[0] && ref_en_q[0]) |=> irq_q)
    else $error("enabled reference 0 failure gave no interrupt");

  chk_evt_lock_irq: assert property (
    (evt_q[0] && evt_en_q[0]) |=> irq_q)
    else $error("enabled lock event gave no interrupt");

  chk_irq_quiet: assert property (
    (evt_q == 4'h0 && mon_q == 32'h0) |=> !irq_q)
    else $error("interrupt with no flag set");

  chk_apb_err: assert property (
    (setup && !mapped) |=> (pslverr_q && pready_q))
    else $error("unmapped access gave no error");

endmodule

/* src/sesb_defines.svh */
`ifndef SESB_DEFINES_SVH
`define SESB_DEFINES_SVH

// Register indices; byte address is four times the index
`define SESB_IDX_REF_FAIL_SUM 6'h02
`define SESB_IDX_LOOP_EVT     6'h04
`define SESB_IDX_MON01        6'h05
`define SESB_IDX_MON23        6'h06
`define SESB_IDX_MON45        6'h07
`define SESB_IDX_MON67        6'h08
`define SESB_IDX_REF_FAIL_EN  6'h09
`define SESB_IDX_LOOP_EVT_EN  6'h0b
`define SESB_IDX_MON_EN01     6'h0c
`define SESB_IDX_MON_EN23     6'h0d
`define SESB_IDX_MON_EN45     6'h0e
`define SESB_IDX_MON_EN67     6'h0f

// Field and register widths
`define SESB_EVT_W            4
`define SESB_MON_W            4
`define SESB_REG_W            8

// Reset values
`define SESB_RST_REF_FAIL_EN  8'h00
`define SESB_RST_LOOP_EVT_EN  4'h0
`define SESB_RST_MON_EN       32'hffffffff

`endif

/* src/sesb_pkg.sv */
package sesb_pkg;

  // Second-loop event pulses; bit 0 is locked
  typedef struct packed {
    logic ref_changed;
    logic holdover;
    logic lost_lock;
    logic locked;
  } sesb_loop_evt_t;

  // One reference's monitor failures; bit 0 is the cycle monitor
  typedef struct packed {
    logic precise_freq;
    logic guard_timer;
    logic coarse_freq;
    logic cycle_mon;
  } sesb_mon_t;

endpackage

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "sesb_defines.svh"

module tb;
  import sesb_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]           paddr, lfsr;
  logic [31:0]          pwdata, prdata;
  logic [3:0]           pstrb;
  sesb_loop_evt_t       loop_evt;
  sesb_mon_t [7:0]      mon_fail;
  logic [32:0]          exq[$];
  int                   errors, samples_checked, cyc;

  sesb_top i_sesb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_evt(loop_evt), .mon_fail(mon_fail), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic final_report();
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Event pulse ev is launched with the access phase, so it lands on the clearing edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                     input logic [32:0] exp, input logic [3:0] ev);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    if (!wr) exq.push_back(exp);
    @(posedge pclk);
    penable  <= 1'b1;
    loop_evt <= ev;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel     <= 1'b0;
    penable  <= 1'b0;
    loop_evt <= '0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0, {25'h0, exp}, 4'h0);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, 33'h0, 4'h0);
  endtask

  task automatic ev_pulse(input logic [3:0] e);
    @(posedge pclk);
    loop_evt <= e;
    @(posedge pclk);
    loop_evt <= '0;
  endtask

  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    cmp({32'h0, irq}, {32'h0, exp});
    @(posedge pclk);
  endtask

  // Read results are judged where pready stands, against the oldest note
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite && exq.size() > 0)
      cmp({pslverr, prdata}, exq.pop_front());
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    loop_evt = '0;
    mon_fail = '0;
    lfsr = 8'h17;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SESB_IDX_REF_FAIL_EN, 8'h00);
    rd(`SESB_IDX_LOOP_EVT_EN, 8'h00);
    for (int i = 0; i < 4; i++) rd(`SESB_IDX_MON_EN01 + 6'(i), 8'hff);
    rd(`SESB_IDX_LOOP_EVT, 8'h00);
    apb(1'b0, 6'h01, 32'h0, {1'b1, 32'h0}, 4'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      ev_pulse(4'(1 << i));
      rd(`SESB_IDX_LOOP_EVT, 8'(1 << i));
      rd(`SESB_IDX_LOOP_EVT, 8'h00);
    end
    ev_pulse(4'h1);
    apb(1'b0, `SESB_IDX_LOOP_EVT, 32'h0, 33'h01, 4'h8);
    rd(`SESB_IDX_LOOP_EVT, 8'h08);
    $display("event test done");
    for (int r = 0; r < 8; r++) begin
      for (int t = 0; t < 4; t++) begin
        @(posedge pclk);
        mon_fail[r][t] <= 1'b1;
        @(posedge pclk);
        mon_fail <= '0;
        rd(`SESB_IDX_REF_FAIL_SUM, 8'(1 << r));
        rd(`SESB_IDX_MON01 + 6'(r / 2), 8'(1 << (4 * (r % 2) + t)));
        rd(`SESB_IDX_MON01 + 6'(r / 2), 8'h00);
      end
    end
    wr(`SESB_IDX_MON01, 8'hff);
    rd(`SESB_IDX_MON01, 8'h00);
    $display("monitor test done");
    wr(`SESB_IDX_LOOP_EVT_EN, 8'h0f);
    ev_pulse(4'h4);
    chk_irq(1'b1);
    rd(`SESB_IDX_LOOP_EVT, 8'h04);
    chk_irq(1'b0);
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      wr(`SESB_IDX_REF_FAIL_EN, lfsr);
      rd(`SESB_IDX_REF_FAIL_EN, lfsr);
      @(posedge pclk);
      mon_fail[k][0] <= 1'b1;
      chk_irq(lfsr[k]);
      mon_fail <= '0;
      rd(`SESB_IDX_MON01 + 6'(k / 2), 8'(1 << (4 * (k % 2))));
    end
    wr(`SESB_IDX_REF_FAIL_EN, 8'h01);
    wr(`SESB_IDX_MON_EN01, 8'hfe);
    @(posedge pclk);
    mon_fail[0][0] <= 1'b1;
    chk_irq(1'b0);
    wr(`SESB_IDX_MON_EN01, 8'hff);
    chk_irq(1'b1);
    mon_fail <= '0;
    rd(`SESB_IDX_MON01, 8'h01);
    $display("interrupt test done");
    final_report();
  end
endmodule
